// file: hdl/otm_converter.sv
`timescale 1ns/1ns
`default_nettype none
// One-shot converter core: sampled digital code stands in for the analog pin
module otm_converter #(
    parameter int DATA_W = 10,
    parameter int DIV = otm_pkg::CONV_CLOCK_DIV,
    parameter int TICKS = otm_pkg::CONV_CLOCK_TICKS
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic start,
    input wire logic [DATA_W-1:0] analog_input_ch,
    output logic busy,
    output logic done,
    output logic [DATA_W-1:0] result
);
    initial begin
        if (DIV < 2 || DIV > 256 || TICKS < 1 || TICKS > 256) begin
            $error("otm_converter: bad divider or tick count");
        end
    end

    logic [DATA_W-1:0] pin_meta;
    logic [DATA_W-1:0] pin_sync;
    logic [7:0] div_cnt;
    logic [7:0] next_div_cnt;
    logic [7:0] tick_cnt;
    logic [7:0] next_tick_cnt;
    logic next_busy;
    logic next_done;
    logic [DATA_W-1:0] next_result;
    logic conv_clock;

    // Divided conversion clock as an enable pulse, only while busy
    always_comb begin
        conv_clock = busy && (div_cnt == 8'(DIV - 1));
        next_div_cnt = busy ? (conv_clock ? 8'h00 : div_cnt + 8'h01) : 8'h00;
        next_tick_cnt = tick_cnt;
        next_busy = busy;
        next_done = 1'b0;
        next_result = result;
        if (!busy && start) begin
            next_busy = 1'b1;
            next_tick_cnt = 8'h00;
        end else if (conv_clock) begin
            if (tick_cnt == 8'(TICKS - 1)) begin
                // One conversion only, then stop
                next_busy = 1'b0;
                next_done = 1'b1;
                next_result = pin_sync;
            end else begin
                next_tick_cnt = tick_cnt + 8'h01;
            end
        end
    end

    // Two stages on the pin since it is asynchronous
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pin_meta <= '0;
            pin_sync <= '0;
            div_cnt <= 8'h00;
            tick_cnt <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            result <= '0;
        end else begin
            pin_meta <= analog_input_ch;
            pin_sync <= pin_meta;
            div_cnt <= next_div_cnt;
            tick_cnt <= next_tick_cnt;
            busy <= next_busy;
            done <= next_done;
            result <= next_result;
        end
    end
endmodule : otm_converter
`default_nettype wire

// file: hdl/otm_pkg.sv
package otm_pkg;
    // Register byte offsets on the Avalon-MM slave
    localparam logic [3:0] OFS_CONV_CONTROL_REG = 4'h0;
    localparam logic [3:0] OFS_CONV_IRQ_STATUS_REG = 4'h4;
    localparam logic [3:0] OFS_CHANNEL_RESULT_REG = 4'h8;
    localparam logic [3:0] OFS_FINAL_VALUE = 4'hC;
    // Upper address window selects the second bank
    localparam logic [4:0] OFS_IRQ_MASK_FULL = 5'h10;
    localparam logic [4:0] OFS_CONFIG = 5'h14;
    // Field positions
    localparam int CONV_START_BIT_POS = 0;
    localparam int CONV_DONE_FLAG_POS = 0;
    localparam int FINAL_VALID_POS = 1;
    localparam int CFG_ENABLE_POS = 0;
    localparam int CFG_AUTO_POS = 1;
    // Reset values
    localparam logic [1:0] RST_IRQ_MASK = 2'h0;
    localparam logic [1:0] RST_CONFIG = 2'h0;
    // Timing
    localparam int CLOCK_HZ = 20_000_000;
    localparam int PERIOD_US = 5_000;
    localparam int PERIOD_CYCLES = (CLOCK_HZ / 1_000_000) * PERIOD_US;
    localparam int CONV_CLOCK_DIV = 4;
    localparam int CONV_CLOCK_TICKS = 16;
    localparam int SET_SIZE = 10;
endpackage : otm_pkg

// file: hdl/otm_top.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - In auto mode, one conversion of the single input channel is made each 5 ms period.
// - A period timer ticks every 5 ms while enabled, and in auto mode each tick starts the next measurement.
// - Conversions start from a write of the start bit, or from the period tick in auto mode.
// - Conversion timing comes from a divided converter clock.
// - Each start performs exactly one conversion and then stops.
// - Writing 1 to the start bit begins a conversion, and the host writes it per sample unless auto mode is set.
// - The start bit returns to 0 by itself when the conversion ends.
// - The done flag is set to 1 when the conversion ends.
// - The finished value is loaded into the channel result register.
// - Each result is added into a running sum for the current set.
// - A result above the stored maximum replaces it.
// - A result below the stored minimum replaces it.
// - After 10 results the extremes are removed and the mean of eight is output.
module otm_top #(
    parameter int DATA_W = 10,
    parameter int PERIOD_CYCLES = otm_pkg::PERIOD_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [DATA_W-1:0] analog_input_ch,
    output logic irq,
    output logic period_tick
);
    localparam int SUM_W = DATA_W + 4;

    // Refuse widths that the readback word or the timer cannot hold
    initial begin
        if (DATA_W < 1 || DATA_W > 16 || PERIOD_CYCLES < 2) begin
            $error("otm_top: unsupported parameters");
        end
    end

    // One-hot bus states; DONE gives the master a cycle to drop its request
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_ACK = 3'b010,
        BUS_DONE = 3'b100
    } otm_bus_e;

    otm_bus_e bus_state;
    otm_bus_e next_bus_state;
    logic [31:0] next_readdata;
    logic next_waitrequest;
    logic conv_start_bit;
    logic next_conv_start_bit;
    logic [1:0] irq_status;
    logic [1:0] next_irq_status;
    logic [1:0] irq_mask;
    logic [1:0] next_irq_mask;
    logic [1:0] config_bits;
    logic [1:0] next_config_bits;
    logic [DATA_W-1:0] channel_result_reg;
    logic [DATA_W-1:0] next_channel_result_reg;
    logic [DATA_W-1:0] final_value;
    logic [DATA_W-1:0] next_final_value;
    logic [SUM_W-1:0] sum;
    logic [SUM_W-1:0] next_sum;
    logic [3:0] count;
    logic [3:0] next_count;
    logic [DATA_W-1:0] max_v;
    logic [DATA_W-1:0] next_max_v;
    logic [DATA_W-1:0] min_v;
    logic [DATA_W-1:0] next_min_v;
    logic [31:0] timer;
    logic [31:0] next_timer;
    logic next_period_tick;
    logic next_irq;
    logic conv_busy;
    logic conv_done;
    logic [DATA_W-1:0] conv_result;
    logic start_pulse;
    logic next_start_pulse;
    logic wr_now;
    logic [SUM_W-1:0] trimmed;
    logic set_complete; // Tenth result folded in, mean due

    // Converter core, started only by the start pulse from a register write or an auto-mode period tick
    otm_converter #(
        .DATA_W(DATA_W),
        .DIV(otm_pkg::CONV_CLOCK_DIV),
        .TICKS(otm_pkg::CONV_CLOCK_TICKS)
    ) u_conv (
        .clock(clock),
        .nrst(nrst),
        .start(start_pulse),
        .analog_input_ch(analog_input_ch),
        .busy(conv_busy),
        .done(conv_done),
        .result(conv_result)
    );

    // Period timer in plain timer mode, runs while enabled
    always_comb begin
        next_timer = timer;
        next_period_tick = 1'b0;
        if (config_bits[otm_pkg::CFG_ENABLE_POS]) begin
            if (timer == 32'(PERIOD_CYCLES - 1)) begin
                next_timer = 32'h0000_0000;
                next_period_tick = 1'b1;
            end else begin
                next_timer = timer + 32'h0000_0001;
            end
        end else begin
            next_timer = 32'h0000_0000;
        end
    end

    // Avalon slave: one wait cycle, answer on the second cycle
    always_comb begin
        next_bus_state = bus_state;
        next_readdata = avs_readdata;
        next_waitrequest = 1'b1;
        wr_now = 1'b0;
        unique case (bus_state)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    next_bus_state = BUS_ACK;
                    next_waitrequest = 1'b0;
                    next_readdata = 32'h0000_0000;
                    if (avs_read) begin
                        case (avs_address)
                            {1'b0, otm_pkg::OFS_CONV_CONTROL_REG}:
                                next_readdata = 32'(conv_start_bit);
                            {1'b0, otm_pkg::OFS_CONV_IRQ_STATUS_REG}:
                                next_readdata = 32'(irq_status);
                            {1'b0, otm_pkg::OFS_CHANNEL_RESULT_REG}:
                                next_readdata = 32'(channel_result_reg);
                            {1'b0, otm_pkg::OFS_FINAL_VALUE}:
                                next_readdata = 32'(final_value);
                            otm_pkg::OFS_IRQ_MASK_FULL:
                                next_readdata = 32'(irq_mask);
                            otm_pkg::OFS_CONFIG:
                                next_readdata = 32'(config_bits);
                            default: next_readdata = 32'h0000_0000;
                        endcase
                    end
                end
            end
            BUS_ACK: begin
                // Write takes effect at the edge where waitrequest is low
                wr_now = avs_write;
                next_bus_state = BUS_DONE;
            end
            BUS_DONE: begin
                next_bus_state = BUS_IDLE;
            end
        endcase
    end

    // Ten-sample reduction; extremes are trimmed once the set is full
    always_comb begin
        next_final_value = final_value;
        next_sum = sum;
        next_count = count;
        next_max_v = max_v;
        next_min_v = min_v;
        set_complete = 1'b0;
        trimmed = sum - SUM_W'(max_v) - SUM_W'(min_v);
        if (conv_done) begin
            if (count == 4'h0) begin
                next_max_v = conv_result;
                next_min_v = conv_result;
            end else begin
                if (conv_result > max_v) begin
                    next_max_v = conv_result;
                end
                if (conv_result < min_v) begin
                    next_min_v = conv_result;
                end
            end
            next_sum = sum + SUM_W'(conv_result);
            next_count = count + 4'h1;
        end else if (count == 4'(otm_pkg::SET_SIZE)) begin
            // Divide by eight by shifting; no done can arrive this soon
            set_complete = 1'b1;
            next_final_value = DATA_W'(trimmed >> 3);
            next_sum = '0;
            next_count = 4'h0;
            next_max_v = '0;
            next_min_v = '0;
        end
    end

    // Control and flag registers; a set beats a same-cycle clear
    always_comb begin
        next_conv_start_bit = conv_start_bit;
        next_irq_status = irq_status;
        next_irq_mask = irq_mask;
        next_config_bits = config_bits;
        next_channel_result_reg = channel_result_reg;
        next_start_pulse = 1'b0;
        if (wr_now) begin
            case (avs_address)
                {1'b0, otm_pkg::OFS_CONV_CONTROL_REG}: begin
                    if (avs_writedata[otm_pkg::CONV_START_BIT_POS] && !conv_start_bit) begin
                        next_conv_start_bit = 1'b1;
                        next_start_pulse = 1'b1;
                    end
                end
                {1'b0, otm_pkg::OFS_CONV_IRQ_STATUS_REG}: begin
                    // Write one to clear
                    next_irq_status = irq_status & ~avs_writedata[1:0];
                end
                otm_pkg::OFS_IRQ_MASK_FULL: next_irq_mask = avs_writedata[1:0];
                otm_pkg::OFS_CONFIG: next_config_bits = avs_writedata[1:0];
                default: begin
                end
            endcase
        end
        // Auto mode lets the period tick stand in for the host's start write
        if (period_tick && config_bits[otm_pkg::CFG_AUTO_POS] && !conv_start_bit) begin
            next_conv_start_bit = 1'b1;
            next_start_pulse = 1'b1;
        end
        if (conv_done) begin
            next_conv_start_bit = 1'b0;
            next_irq_status[otm_pkg::CONV_DONE_FLAG_POS] = 1'b1;
            next_channel_result_reg = conv_result;
        end
        if (set_complete) begin
            next_irq_status[otm_pkg::FINAL_VALID_POS] = 1'b1;
        end
        next_irq = |(next_irq_status & next_irq_mask);
    end

    // Bus handshake registers; waitrequest idles high
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bus_state <= BUS_IDLE;
            avs_readdata <= 32'h0000_0000;
            avs_waitrequest <= 1'b1;
        end else begin
            bus_state <= next_bus_state;
            avs_readdata <= next_readdata;
            avs_waitrequest <= next_waitrequest;
        end
    end

    // Period timer registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            timer <= 32'h0000_0000;
            period_tick <= 1'b0;
        end else begin
            timer <= next_timer;
            period_tick <= next_period_tick;
        end
    end

    // Control and flag registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            conv_start_bit <= 1'b0;
            irq_status <= 2'h0;
            irq_mask <= otm_pkg::RST_IRQ_MASK;
            config_bits <= otm_pkg::RST_CONFIG;
            channel_result_reg <= '0;
            irq <= 1'b0;
            start_pulse <= 1'b0;
        end else begin
            conv_start_bit <= next_conv_start_bit;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            config_bits <= next_config_bits;
            channel_result_reg <= next_channel_result_reg;
            irq <= next_irq;
            start_pulse <= next_start_pulse;
        end
    end

    // Reduction registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            final_value <= '0;
            sum <= '0;
            count <= 4'h0;
            max_v <= '0;
            min_v <= '0;
        end else begin
            final_value <= next_final_value;
            sum <= next_sum;
            count <= next_count;
            max_v <= next_max_v;
            min_v <= next_min_v;
        end
    end
endmodule : otm_top
`default_nettype wire

// file: verif/oneshot_adc_trimmed_mean_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module oneshot_adc_trimmed_mean_test;
    localparam int P = 200;
    localparam logic [4:0] A_CTL = {1'b0, otm_pkg::OFS_CONV_CONTROL_REG};
    localparam logic [4:0] A_STS = {1'b0, otm_pkg::OFS_CONV_IRQ_STATUS_REG};
    localparam logic [4:0] A_RES = {1'b0, otm_pkg::OFS_CHANNEL_RESULT_REG};
    localparam logic [4:0] A_FIN = {1'b0, otm_pkg::OFS_FINAL_VALUE};
    localparam logic [4:0] A_MSK = otm_pkg::OFS_IRQ_MASK_FULL;
    localparam logic [4:0] A_CFG = otm_pkg::OFS_CONFIG;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq, period_tick;
    logic [9:0] level = 10'h000;
    logic [9:0] code;
    logic [31:0] rd;
    int fails = 0;
    int compares = 0;
    logic [9:0] tbl [10] = '{10'h12c, 10'h200, 10'h064, 10'h2bc, 10'h0fa,
                             10'h384, 10'h032, 10'h258, 10'h190, 10'h14d};
    // 50 ns period
    always #25 clock = ~clock;
    otm_analog_src #(.DATA_W(10)) u_src (.clock(clock), .nrst(nrst), .level(level), .code(code));
    otm_top #(.DATA_W(10), .PERIOD_CYCLES(P)) dut (
        .clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .analog_input_ch(code), .irq(irq),
        .period_tick(period_tick));
    // Request held until waitrequest is sampled low
    task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : bus_write
    task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask : bus_read
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    // One set of ten tick-paced conversions; expected mean kept here
    task automatic run_set(input logic [9:0] add);
        logic [13:0] sum;
        logic [9:0] mx, mn, v;
        int n;
        sum = 14'h0000;
        mx = 10'h000;
        mn = 10'h3ff;
        for (int i = 0; i < 10; i++) begin
            v = tbl[i] + add;
            level <= v;
            sum += {4'h0, v};
            if (i == 0 || v > mx) mx = v;
            if (i == 0 || v < mn) mn = v;
            repeat (4) @(posedge clock);
            for (n = 0; n < P + 10 && period_tick !== 1'b1; n++) @(posedge clock);
            `CHK("tick", 1'b1, period_tick)
            bus_write(A_CTL, 32'h0000_0001);
            bus_read(A_CTL, rd);
            `CHK("start bit", 32'h0000_0001, rd)
            for (n = 0; n < 300 && irq !== 1'b1; n++) @(posedge clock);
            `CHK("done irq", 1'b1, irq)
            bus_read(A_CTL, rd);
            `CHK("start bit end", 32'h0000_0000, rd)
            bus_read(A_STS, rd);
            `CHK("done flag", 1'b1, rd[0])
            bus_read(A_RES, rd);
            `CHK("result", {22'h0, v}, rd)
            bus_write(A_STS, 32'h0000_0001);
            bus_read(A_STS, rd);
            `CHK("done clear", 1'b0, rd[0])
        end
        bus_read(A_STS, rd);
        `CHK("final valid", 1'b1, rd[1])
        bus_read(A_FIN, rd);
        `CHK("mean", {18'h0, (sum - {4'h0, mx} - {4'h0, mn}) >> 3}, rd)
    endtask : run_set
    initial begin
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        bus_read(A_CFG, rd);
        `CHK("config reset", 32'h0000_0000, rd)
        bus_read(A_MSK, rd);
        `CHK("mask reset", 32'h0000_0000, rd)
        bus_write(5'h18, 32'hffff_ffff);
        bus_read(5'h18, rd);
        `CHK("unmapped", 32'h0000_0000, rd)
        bus_write(A_MSK, 32'h0000_0003);
        bus_write(A_CFG, 32'h0000_0001);
        run_set(10'h000);
        // Final-valid holds irq; mask, unmask, then clear it
        bus_write(A_MSK, 32'h0000_0000);
        repeat (3) @(posedge clock);
        `CHK("irq masked", 1'b0, irq)
        bus_write(A_MSK, 32'h0000_0003);
        repeat (3) @(posedge clock);
        `CHK("irq unmasked", 1'b1, irq)
        bus_write(A_STS, 32'h0000_0003);
        repeat (3) @(posedge clock);
        `CHK("irq cleared", 1'b0, irq)
        // With auto mode off, ticks alone must not start a conversion
        repeat (2 * P) @(posedge clock);
        bus_read(A_STS, rd);
        `CHK("no retrigger", 32'h0000_0000, rd)
        run_set(10'h005);
        // Auto mode: the tick itself raises the start bit, no host write
        bus_write(A_STS, 32'h0000_0003);
        bus_write(A_CFG, 32'h0000_0003);
        for (int k = 0; k < P + 100 && irq !== 1'b1; k++) @(posedge clock);
        `CHK("auto irq", 1'b1, irq)
        bus_read(A_RES, rd);
        `CHK("auto result", {22'h0, level}, rd)
        bus_read(A_CTL, rd);
        `CHK("auto start end", 32'h0000_0000, rd)
        test_done;
    end
    // Two sets take about 4000 cycles
    initial begin
        #(30000 * 50);
        fails++;
        test_done;
    end
endmodule : oneshot_adc_trimmed_mean_test
`default_nettype wire

// file: verif/otm_analog_src.sv
`timescale 1ns/1ns
`default_nettype none
// Analog pin model: the level settles one cycle after the bench sets it
module otm_analog_src #(
    parameter int DATA_W = 10
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [DATA_W-1:0] level,
    output logic [DATA_W-1:0] code
);
    // Pin always driven, so no release state is modelled
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            code <= '0;
        end else begin
            code <= level;
        end
    end
endmodule : otm_analog_src
`default_nettype wire

// file: verif/otm_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// Port checks on bus handshake, period tick and interrupt
module otm_monitor #(
    parameter int DATA_W = 10,
    parameter int PERIOD_CYCLES = 200
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [DATA_W-1:0] analog_input_ch,
    input wire logic irq,
    input wire logic period_tick
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    logic [31:0] gap;
    logic armed;
    // Cycles since last tick; first tick after reset has no reference
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            gap <= 32'h0000_0000;
            armed <= 1'b0;
        end else begin
            gap <= period_tick ? 32'h0000_0000 : gap + 32'h0000_0001;
            armed <= armed | period_tick;
        end
    end
    a_reset_idle: assert property ($rose(nrst) |-> avs_waitrequest && !irq && !period_tick)
        else $error("outputs not idle after reset");
    a_ack_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_ack_bound: assert property ((avs_read || avs_write) |-> ##[0:3] !avs_waitrequest)
        else $error("request not answered in time");
    a_tick_pulse: assert property (period_tick |=> !period_tick)
        else $error("tick longer than one cycle");
    a_tick_period: assert property (period_tick && armed |-> gap == PERIOD_CYCLES - 1)
        else $error("tick spacing wrong");
    a_mask_quiet: assert property (avs_write && !avs_waitrequest && avs_address == 5'h10
        && avs_writedata[1:0] == 2'h0 |-> ##[1:2] !irq)
        else $error("irq stays high with mask cleared");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 5'h14
        |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_final_width: assert property (avs_read && !avs_waitrequest && avs_address == 5'h0c
        |-> avs_readdata[31:DATA_W] == '0)
        else $error("final value upper bits set");
    c_tick: cover property (period_tick);
    c_irq: cover property ($rose(irq));
    c_final: cover property (avs_read && !avs_waitrequest && avs_address == 5'h0c);
endmodule : otm_monitor
bind otm_top otm_monitor #(.DATA_W(DATA_W), .PERIOD_CYCLES(PERIOD_CYCLES)) u_mon (
    .clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .analog_input_ch(analog_input_ch), .irq(irq),
    .period_tick(period_tick));
`default_nettype wire
